//--- wpd_port.sv
// Purpose: 16-pin port shared with the external data bus, plus companion port pin mux
// Assumes: pins synchronous to clk_in; sys_rst_in is the external power-on reset
// Notes:   pin outputs are registered, so they follow a register write by one cycle
`timescale 1ns/100ps

// Summary of operation
// - sixteen bidirectional pins, 15 down to 0, on the wide port
// - modes 0/1 all data bus; mode 2 per-pin select; single-chip general only
// - 16-bit read/write pin data register, bit n maps to pin n
// - general output pin drives last written data bit
// - output pin read returns stored bit regardless of pin level
// - input pin read returns live pin level
// - writes on input pins update the stored bit only
// - direction 0 reads pin, 1 reads register; drive only for general output
// - data register cleared only by power-on reset, kept otherwise
// - register at its listed address; byte, halfword and word access
// - companion pins general I/O; extended modes add dma ack and address hold
// - companion pins 7..0 timer I/O; pins 3..0 dma signals in extended modes
module wpd_port (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [1:0]  mode_in,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [15:0] wide_port_pin_in,
	output logic [15:0]      wide_port_pin_out,
	output logic [15:0]      wide_port_pin_oe_out,
	input  wire logic [15:0] ext_data_bus_bit_in,
	input  wire logic        ext_data_bus_oe_in,
	output logic [15:0]      ext_data_bus_bit_out,
	input  wire logic [15:0] companion_port_pin_in,
	output logic [15:0]      companion_port_pin_out,
	output logic [15:0]      companion_port_pin_oe_out,
	input  wire logic [7:0]  timer_capcomp_io_in,
	input  wire logic [7:0]  timer_capcomp_oe_in,
	output logic [7:0]       timer_capcomp_io_out,
	input  wire logic        dma_ack_in_ch0,
	input  wire logic        dma_ack_in_ch1,
	input  wire logic        address_hold_in,
	input  wire logic        dma_req_ack_in_ch0,
	input  wire logic        dma_req_ack_in_ch1,
	output logic             dma_req_out_ch0,
	output logic             dma_req_out_ch1
);

	// byte-lane merge of a 16-bit register from the low word lanes
	function automatic logic [15:0] wpd_merge(input logic [15:0] old_v,
	                                          input logic [31:0] wd,
	                                          input logic [3:0]  ws);
		logic [15:0] r;
		r = old_v;
		if (ws[0]) begin
			r[7:0] = wd[7:0];
		end
		if (ws[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : wpd_merge

	// read source per bit: direction 1 gives stored value, 0 gives pin level
	function automatic logic [15:0] wpd_rd(input logic [15:0] dir_v,
	                                       input logic [15:0] reg_v,
	                                       input logic [15:0] pin_v);
		return (dir_v & reg_v) | (~dir_v & pin_v);
	endfunction : wpd_rd

	wpd_pkg::wpd_regs_t  regs_ff;
	wpd_pkg::wpd_regs_t  nxt_regs;
	wpd_pkg::wpd_mode_t  mode_ff;
	wpd_pkg::wpd_mode_t  nxt_mode;
	wpd_pkg::wpd_drive_t wide_ff;
	wpd_pkg::wpd_drive_t nxt_wide;
	wpd_pkg::wpd_drive_t cmp_ff;
	wpd_pkg::wpd_drive_t nxt_cmp;
	logic [15:0]         ext_bus_ff;
	logic [15:0]         nxt_ext_bus;
	logic [7:0]          tmr_ff;
	logic [7:0]          nxt_tmr;
	logic [1:0]          dreq_ff;
	logic [1:0]          nxt_dreq;

	logic                aw_have_ff;
	logic                nxt_aw_have;
	logic                w_have_ff;
	logic                nxt_w_have;
	logic [31:0]         aw_addr_ff;
	logic [31:0]         nxt_aw_addr;
	logic [31:0]         w_data_ff;
	logic [31:0]         nxt_w_data;
	logic [3:0]          w_strb_ff;
	logic [3:0]          nxt_w_strb;
	logic                awready_ff;
	logic                nxt_awready;
	logic                wready_ff;
	logic                nxt_wready;
	logic                bvalid_ff;
	logic                nxt_bvalid;
	logic [1:0]          bresp_ff;
	logic [1:0]          nxt_bresp;
	logic                arready_ff;
	logic                nxt_arready;
	logic                rvalid_ff;
	logic                nxt_rvalid;
	logic [31:0]         rdata_ff;
	logic [31:0]         nxt_rdata;
	logic [1:0]          rresp_ff;
	logic [1:0]          nxt_rresp;

	logic                ext_mode;
	logic [15:0]         bus_owned;

	// extended modes and per-pin bus ownership
	assign ext_mode  = (mode_ff != wpd_pkg::WPD_MODE_SINGLE);
	always_comb begin
		unique case (mode_ff)
			wpd_pkg::WPD_MODE_EXT_NOROM0: bus_owned = 16'hFFFF;
			wpd_pkg::WPD_MODE_EXT_NOROM1: bus_owned = 16'hFFFF;
			wpd_pkg::WPD_MODE_EXT_ROM:    bus_owned = regs_ff.func;
			default:                      bus_owned = 16'h0000;
		endcase
	end

	// axi write and read channels, register updates
	always_comb begin
		nxt_regs    = regs_ff;
		nxt_aw_have = aw_have_ff;
		nxt_w_have  = w_have_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_data  = w_data_ff;
		nxt_w_strb  = w_strb_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		nxt_rvalid  = rvalid_ff;
		nxt_rdata   = rdata_ff;
		nxt_rresp   = rresp_ff;
		nxt_mode    = mode_ff;
		if (s_axi_awvalid && awready_ff) begin
			nxt_aw_have = 1'b1;
			nxt_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_ff) begin
			nxt_w_have = 1'b1;
			nxt_w_data = s_axi_wdata;
			nxt_w_strb = s_axi_wstrb;
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		// apply a write once address and data are both held
		if (aw_have_ff && w_have_ff && !bvalid_ff) begin
			nxt_aw_have = 1'b0;
			nxt_w_have  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = wpd_pkg::RESP_OKAY;
			unique case (aw_addr_ff)
				wpd_pkg::ADDR_PIN_DATA:
					nxt_regs.pin_data = wpd_merge(regs_ff.pin_data, w_data_ff,
					                              w_strb_ff);
				wpd_pkg::ADDR_DIRECTION:
					nxt_regs.dir = wpd_merge(regs_ff.dir, w_data_ff, w_strb_ff);
				wpd_pkg::ADDR_FUNC_SEL:
					nxt_regs.func = wpd_merge(regs_ff.func, w_data_ff, w_strb_ff);
				wpd_pkg::ADDR_CMP_DATA:
					nxt_regs.cmp_data = wpd_merge(regs_ff.cmp_data, w_data_ff,
					                              w_strb_ff);
				wpd_pkg::ADDR_CMP_DIR:
					nxt_regs.cmp_dir = wpd_merge(regs_ff.cmp_dir, w_data_ff, w_strb_ff);
				wpd_pkg::ADDR_CMP_FUNC: begin
					nxt_regs.cmp_func[15:0] = wpd_merge(regs_ff.cmp_func[15:0],
					                                    w_data_ff, w_strb_ff);
					if (w_strb_ff[2]) begin
						nxt_regs.cmp_func[20:16] = w_data_ff[20:16];
					end
				end
				default: nxt_bresp = wpd_pkg::RESP_SLVERR;  // unmapped
			endcase
		end
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		// read data is captured at the address handshake
		if (s_axi_arvalid && arready_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = wpd_pkg::RESP_OKAY;
			nxt_rdata  = 32'h0000_0000;
			unique case (s_axi_araddr)
				wpd_pkg::ADDR_PIN_DATA:
					nxt_rdata[15:0] = wpd_rd(regs_ff.dir, regs_ff.pin_data,
					                         wide_port_pin_in);
				wpd_pkg::ADDR_DIRECTION: nxt_rdata[15:0] = regs_ff.dir;
				wpd_pkg::ADDR_FUNC_SEL: begin
					nxt_rdata[15:0] = regs_ff.func;
					nxt_rdata[wpd_pkg::FS_MODE_LO +: 2] = mode_ff;
				end
				wpd_pkg::ADDR_CMP_DATA:
					nxt_rdata[15:0] = wpd_rd(regs_ff.cmp_dir, regs_ff.cmp_data,
					                         companion_port_pin_in);
				wpd_pkg::ADDR_CMP_DIR:  nxt_rdata[15:0] = regs_ff.cmp_dir;
				wpd_pkg::ADDR_CMP_FUNC: nxt_rdata[20:0] = regs_ff.cmp_func;
				default:                nxt_rresp = wpd_pkg::RESP_SLVERR;
			endcase
		end
		// mode pins are sampled on every clock outside reset
		nxt_mode = wpd_pkg::wpd_mode_t'(mode_in);
	end

	// ready flags: one write and one read in flight
	always_comb begin
		nxt_awready = !nxt_aw_have && !nxt_bvalid;
		nxt_wready  = !nxt_w_have && !nxt_bvalid;
		nxt_arready = !nxt_rvalid;
	end

	// wide port pin drive and data bus capture
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (bus_owned[i]) begin
				nxt_wide.val[i] = ext_data_bus_bit_in[i];
				nxt_wide.oe[i]  = ext_data_bus_oe_in;
			end else begin
				nxt_wide.val[i] = regs_ff.pin_data[i];
				nxt_wide.oe[i]  = regs_ff.dir[i];
			end
		end
		nxt_ext_bus = wide_port_pin_in;
	end

	// companion port pin functions
	always_comb begin
		nxt_cmp.val = regs_ff.cmp_data;
		nxt_cmp.oe  = regs_ff.cmp_dir;
		for (int i = 0; i < 8; i++) begin
			if (regs_ff.cmp_func[i]) begin
				nxt_cmp.val[i] = timer_capcomp_io_in[i];
				nxt_cmp.oe[i]  = timer_capcomp_oe_in[i];
			end
		end
		if (ext_mode) begin
			for (int i = 0; i < 4; i++) begin
				if (regs_ff.cmp_func[wpd_pkg::CF_DMA_LO + i]) begin
					nxt_cmp.oe[i] = i[0];
					nxt_cmp.val[i] = i[1] ? dma_req_ack_in_ch1 : dma_req_ack_in_ch0;
				end
			end
			if (regs_ff.cmp_func[wpd_pkg::CMP_PIN_ACK1]) begin
				nxt_cmp.val[wpd_pkg::CMP_PIN_ACK1] = dma_ack_in_ch1;
				nxt_cmp.oe[wpd_pkg::CMP_PIN_ACK1]  = 1'b1;
			end
			if (regs_ff.cmp_func[wpd_pkg::CMP_PIN_ACK0]) begin
				nxt_cmp.val[wpd_pkg::CMP_PIN_ACK0] =
				    regs_ff.cmp_func[wpd_pkg::CF_AH_SEL] ? address_hold_in
				                                         : dma_ack_in_ch0;
				nxt_cmp.oe[wpd_pkg::CMP_PIN_ACK0] = 1'b1;
			end
		end
		nxt_tmr  = companion_port_pin_in[7:0];
		nxt_dreq[0] = ext_mode && regs_ff.cmp_func[wpd_pkg::CF_DMA_LO]
		              && companion_port_pin_in[0];
		nxt_dreq[1] = ext_mode && regs_ff.cmp_func[wpd_pkg::CF_DMA_LO + 2]
		              && companion_port_pin_in[2];
	end

	// state registers; sys_rst_in is the power-on reset
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			regs_ff.pin_data <= wpd_pkg::RST_PIN_DATA;
			regs_ff.dir      <= wpd_pkg::RST_DIR;
			regs_ff.func     <= wpd_pkg::RST_FUNC;
			regs_ff.cmp_data <= wpd_pkg::RST_PIN_DATA;
			regs_ff.cmp_dir  <= wpd_pkg::RST_DIR;
			regs_ff.cmp_func <= wpd_pkg::RST_CMP_FUNC;
			mode_ff    <= wpd_pkg::WPD_MODE_SINGLE;
			wide_ff    <= '0;
			cmp_ff     <= '0;
			ext_bus_ff <= 16'h0000;
			tmr_ff     <= 8'h00;
			dreq_ff    <= 2'b00;
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			aw_addr_ff <= 32'h0000_0000;
			w_data_ff  <= 32'h0000_0000;
			w_strb_ff  <= 4'h0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= wpd_pkg::RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= wpd_pkg::RESP_OKAY;
		end else begin
			regs_ff    <= nxt_regs;
			mode_ff    <= nxt_mode;
			wide_ff    <= nxt_wide;
			cmp_ff     <= nxt_cmp;
			ext_bus_ff <= nxt_ext_bus;
			tmr_ff     <= nxt_tmr;
			dreq_ff    <= nxt_dreq;
			aw_have_ff <= nxt_aw_have;
			w_have_ff  <= nxt_w_have;
			aw_addr_ff <= nxt_aw_addr;
			w_data_ff  <= nxt_w_data;
			w_strb_ff  <= nxt_w_strb;
			awready_ff <= nxt_awready;
			wready_ff  <= nxt_wready;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			arready_ff <= nxt_arready;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= nxt_rdata;
			rresp_ff   <= nxt_rresp;
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready             = awready_ff;
	assign s_axi_wready              = wready_ff;
	assign s_axi_bvalid              = bvalid_ff;
	assign s_axi_bresp               = bresp_ff;
	assign s_axi_arready             = arready_ff;
	assign s_axi_rvalid              = rvalid_ff;
	assign s_axi_rdata               = rdata_ff;
	assign s_axi_rresp               = rresp_ff;
	assign wide_port_pin_out         = wide_ff.val;
	assign wide_port_pin_oe_out      = wide_ff.oe;
	assign ext_data_bus_bit_out      = ext_bus_ff;
	assign companion_port_pin_out    = cmp_ff.val;
	assign companion_port_pin_oe_out = cmp_ff.oe;
	assign timer_capcomp_io_out      = tmr_ff;
	assign dma_req_out_ch0           = dreq_ff[0];
	assign dma_req_out_ch1           = dreq_ff[1];

endmodule : wpd_port

//--- wpd_pkg.sv
// Purpose: constants and types shared by the wide data-bus port block
// Assumes: 32-bit AXI4-Lite register access, 16-pin ports
// Notes:   the data register index is kept as printed; byte address is four times it
package wpd_pkg;
	// printed offset of the pin data register, used as a word index
	localparam logic [31:0] WIDE_PORT_PIN_DATA_IDX = 32'hFFFF83A2;
	// byte addresses; the product is cut to 32 bits on purpose
	localparam logic [31:0] ADDR_PIN_DATA   = 32'(WIDE_PORT_PIN_DATA_IDX * 4);
	localparam logic [31:0] ADDR_DIRECTION  = ADDR_PIN_DATA + 32'h0000_0004;
	localparam logic [31:0] ADDR_FUNC_SEL   = ADDR_PIN_DATA + 32'h0000_0008;
	localparam logic [31:0] ADDR_CMP_DATA   = ADDR_PIN_DATA + 32'h0000_000C;
	localparam logic [31:0] ADDR_CMP_DIR    = ADDR_PIN_DATA + 32'h0000_0010;
	localparam logic [31:0] ADDR_CMP_FUNC   = ADDR_PIN_DATA + 32'h0000_0014;

	// reset values
	localparam logic [15:0] RST_PIN_DATA = 16'h0000;
	localparam logic [15:0] RST_DIR      = 16'h0000;
	localparam logic [15:0] RST_FUNC     = 16'h0000;
	localparam logic [20:0] RST_CMP_FUNC = 21'h000000;

	// field positions in the companion function register
	localparam int CF_DMA_LO   = 16;  // bits 19:16 pick dma over timer, pins 3..0
	localparam int CF_AH_SEL   = 20;  // pin 14: 1 = address hold, 0 = dma ack 0
	localparam int FS_MODE_LO  = 16;  // mode readback in function select register
	localparam int CMP_PIN_ACK1 = 15;
	localparam int CMP_PIN_ACK0 = 14;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// operating modes from the mode pins
	typedef enum logic [1:0] {
		WPD_MODE_EXT_NOROM0 = 2'b00,
		WPD_MODE_EXT_NOROM1 = 2'b01,
		WPD_MODE_EXT_ROM    = 2'b10,
		WPD_MODE_SINGLE     = 2'b11
	} wpd_mode_t;

	// drive of a 16-pin port
	typedef struct packed {
		logic [15:0] val;
		logic [15:0] oe;
	} wpd_drive_t;

	// software-visible state
	typedef struct packed {
		logic [15:0] pin_data;
		logic [15:0] dir;
		logic [15:0] func;
		logic [15:0] cmp_data;
		logic [15:0] cmp_dir;
		logic [20:0] cmp_func;
	} wpd_regs_t;
endpackage : wpd_pkg

//--- wpd_port_chk.sv
// Purpose: port-level checks for the wide data-bus port
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every wpd_port instance
`timescale 1ns/100ps
module wpd_port_chk (
	input wire logic        clk_in,
	input wire logic        sys_rst_in,
	input wire logic [1:0]  mode_in,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [15:0] wide_port_pin_in,
	input wire logic [15:0] wide_port_pin_out,
	input wire logic [15:0] wide_port_pin_oe_out,
	input wire logic [15:0] ext_data_bus_bit_in,
	input wire logic        ext_data_bus_oe_in,
	input wire logic [15:0] ext_data_bus_bit_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// write address with data taken, read address taken
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// bus controller owns pins in modes 0 and 1
	property p_bus_owns;
		!$past(sys_rst_in) && $past(mode_in) <= 2'h1 && ext_data_bus_oe_in
		|=> wide_port_pin_out == $past(ext_data_bus_bit_in) && wide_port_pin_oe_out == 16'hFFFF;
	endproperty
	// register bus answers and holds
	AST_WR_ANSWER: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	AST_RD_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read response missing");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	AST_ONE_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == wpd_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read returned data");
	// pins and reset
	AST_POR_QUIET: assert property ($fell(sys_rst_in) |-> wide_port_pin_oe_out == 16'h0 && !s_axi_bvalid)
		else $error("pins driven after power-on reset");
	AST_BUS_OWNS: assert property (p_bus_owns)
		else $error("bus controller not driving pins");
	AST_BUS_SEES: assert property (!$past(sys_rst_in) |-> ext_data_bus_bit_out == $past(wide_port_pin_in))
		else $error("bus controller sees stale pins");
endmodule : wpd_port_chk

bind wpd_port wpd_port_chk u_chk (.clk_in, .sys_rst_in, .mode_in, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wide_port_pin_in,
	.wide_port_pin_out, .wide_port_pin_oe_out, .ext_data_bus_bit_in, .ext_data_bus_oe_in,
	.ext_data_bus_bit_out);

//--- wpd_pins_model.sv
// Purpose: external circuitry on a 16-pin port
// Assumes: outside drive always present, device drive wins where enabled
// Notes:   one instance per port
`timescale 1ns/100ps
module wpd_pins_model (
	input  wire logic [15:0] drive_in,
	input  wire logic [15:0] oe_in,
	input  wire logic [15:0] ext_in,
	output logic [15:0]      level_out
);
	// wire level from both parties
	assign level_out = (drive_in & oe_in) | (ext_in & ~oe_in);
endmodule : wpd_pins_model

//--- wpd_port_test.sv
// Purpose: self-checking bench for the wide data-bus port
// Assumes: single-chip mode after reset, pins resolved by wpd_pins_model
// Notes:   pin checks wait three edges: mode, pin drive and bus capture are each registered
`timescale 1ns/100ps
module wpd_port_test;
	localparam logic [31:0] DAT  = wpd_pkg::ADDR_PIN_DATA;
	localparam logic [31:0] DIR  = wpd_pkg::ADDR_DIRECTION;
	logic        clk_in = 1'h0, sys_rst_in = 1'h1;
	logic [1:0]  mode_in = 2'h3;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, rd;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ext_data_bus_oe_in = 1'h0;
	logic        dma_ack_in_ch0 = 1'h0, dma_ack_in_ch1 = 1'h0;
	logic        address_hold_in = 1'h0, dma_req_ack_in_ch0 = 1'h0, dma_req_ack_in_ch1 = 1'h0;
	logic [7:0]  tmr_io = 8'h00, tmr_oe = 8'h00, timer_capcomp_io_out;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [15:0] ext_data_bus_bit_in = 16'h0, wide_ext = 16'h0, cmp_ext = 16'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        dma_req_out_ch0, dma_req_out_ch1;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata;
	logic [15:0] wide_port_pin_in, wide_port_pin_out, wide_port_pin_oe_out, ext_data_bus_bit_out;
	logic [15:0] companion_port_pin_in, companion_port_pin_out, companion_port_pin_oe_out;
	int          miscompares = 0, checks_done = 0, cycles = 0;

	wpd_port uut (.clk_in, .sys_rst_in, .mode_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .wide_port_pin_in, .wide_port_pin_out, .wide_port_pin_oe_out,
		.ext_data_bus_bit_in, .ext_data_bus_oe_in, .ext_data_bus_bit_out, .companion_port_pin_in,
		.companion_port_pin_out, .companion_port_pin_oe_out, .timer_capcomp_io_in(tmr_io),
		.timer_capcomp_oe_in(tmr_oe), .timer_capcomp_io_out, .dma_ack_in_ch0, .dma_ack_in_ch1,
		.address_hold_in, .dma_req_ack_in_ch0, .dma_req_ack_in_ch1,
		.dma_req_out_ch0, .dma_req_out_ch1);
	wpd_pins_model u_wide (.drive_in(wide_port_pin_out), .oe_in(wide_port_pin_oe_out),
		.ext_in(wide_ext), .level_out(wide_port_pin_in));
	wpd_pins_model u_cmp (.drive_in(companion_port_pin_out), .oe_in(companion_port_pin_oe_out),
		.ext_in(cmp_ext), .level_out(companion_port_pin_in));

	// clock and hang guard
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one write, address and data offered together
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_in);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		do begin
			@(posedge clk_in);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		rsp = s_axi_bresp;
	endtask : wr

	// one read, result left in rd and rsp
	task automatic rdt(input logic [31:0] a);
		@(posedge clk_in);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		do begin
			@(posedge clk_in);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		rd  = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask : rdt

	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		rdt(a);
		check(rd, e);
		check(rsp, wpd_pkg::RESP_OKAY);
	endtask : rdc

	task automatic settle();
		repeat (3) @(posedge clk_in);
		#1;
	endtask : settle

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out

	// main sequence
	initial begin
		repeat (4) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		wr(DIR, 32'h0000FFFF, 4'hF);
		rdc(DAT, 32'h0);
		wr(DAT, 32'h0000A5C3, 4'hF);
		wide_ext <= 16'h5A3C;
		settle();
		check(wide_port_pin_out, 16'hA5C3);
		check(wide_port_pin_oe_out, 16'hFFFF);
		rdc(DAT, 16'hA5C3);
		// upper byte turned to input
		wr(DIR, 32'h000000FF, 4'hF);
		rdc(DAT, 16'h5AC3);
		wr(DAT, 32'h00001234, 4'hF);
		settle();
		check({wide_port_pin_oe_out, wide_port_pin_out[7:0]}, 24'h00FF34);
		wr(DIR, 32'h0000FFFF, 4'hF);
		rdc(DAT, 16'h1234);
		// single byte lanes
		wr(DAT, 32'hFFFFABCD, 4'h2);
		wr(DAT, 32'hFFFFFF56, 4'h1);
		rdc(DAT, 16'hAB56);
		// modes 0 and 1 hand the pins to the bus controller
		ext_data_bus_oe_in  <= 1'h1;
		ext_data_bus_bit_in <= 16'hBEEF;
		for (int m = 0; m < 2; m++) begin
			mode_in <= m[1:0];
			settle();
			check(wide_port_pin_out, 16'hBEEF);
			check(ext_data_bus_bit_out, 16'hBEEF);
			rdc(DAT, 16'hAB56);
		end
		// mode 2: low byte bus, high byte general output
		mode_in <= 2'h2;
		wr(wpd_pkg::ADDR_FUNC_SEL, 32'h000000FF, 4'hF);
		settle();
		check(wide_port_pin_out, 16'hABEF);
		rdc(wpd_pkg::ADDR_FUNC_SEL, 32'h000200FF);
		// unmapped place
		wr(DAT + 32'h40, 32'h1, 4'hF);
		check(rsp, wpd_pkg::RESP_SLVERR);
		rdt(DAT + 32'h40);
		check(rsp, wpd_pkg::RESP_SLVERR);
		check(rd, 32'h0);
		// companion port: plain output, then dma routing
		mode_in <= 2'h3;
		wr(wpd_pkg::ADDR_CMP_DIR, 32'h0000FFFF, 4'hF);
		wr(wpd_pkg::ADDR_CMP_DATA, 32'h00008001, 4'hF);
		settle();
		check(companion_port_pin_out, 16'h8001);
		@(posedge clk_in);
		mode_in        <= 2'h0;
		dma_ack_in_ch0 <= 1'h1;
		cmp_ext        <= 16'h0005;
		wr(wpd_pkg::ADDR_CMP_FUNC, 32'h000FC000, 4'h7);
		settle();
		check(companion_port_pin_out[15:14], 2'h1);
		check({dma_req_out_ch1, dma_req_out_ch0}, 2'h3);
		rdc(wpd_pkg::ADDR_CMP_DATA, 32'h8001);
		// timer drives pins 7..4, request-acks on pins 1 and 3
		@(posedge clk_in);
		tmr_io             <= 8'hA0;
		tmr_oe             <= 8'hF0;
		dma_req_ack_in_ch0 <= 1'h1;
		wr(wpd_pkg::ADDR_CMP_FUNC, 32'h000000F0, 4'h1);
		settle();
		check(companion_port_pin_out[7:4], 4'hA);
		check(companion_port_pin_oe_out[3:0], 4'hA);
		check(timer_capcomp_io_out, 8'hA7);
		// pin 14 as address hold, dma lines released
		@(posedge clk_in);
		address_hold_in <= 1'h1;
		dma_ack_in_ch0  <= 1'h0;
		wr(wpd_pkg::ADDR_CMP_FUNC, 32'h00100000, 4'h4);
		settle();
		check(companion_port_pin_out[15:12], 4'h4);
		check({dma_req_out_ch1, dma_req_out_ch0}, 2'h0);
		// power-on reset clears the stored bits
		@(posedge clk_in);
		sys_rst_in <= 1'h1;
		repeat (4) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		mode_in    <= 2'h3;
		wr(DIR, 32'h0000FFFF, 4'hF);
		rdc(DAT, 32'h0);
		close_out();
	end
endmodule : wpd_port_test
